// [design/internal_set_speed_selector.sv]
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "iss_defines.svh"

module internal_set_speed_selector (
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   // input terminals, low means on
   input  wire logic [`ISS_TERM_N-1:0]  input_terminal_n,
   // axi4-lite slave
   input  wire logic [`ISS_AXI_AW-1:0]  s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [`ISS_AXI_AW-1:0]  s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // speed reference
   output logic                         mode_active,
   output logic [`ISS_CMD_W-1:0]        speed_cmd,
   output logic                         speed_reverse,
   output logic                         motor_stop,
   output logic [1:0]                   preset_index,
   output logic                         speed_clamped
);

   iss_pkg::iss_state_t     q;
   iss_pkg::iss_state_t     d;
   logic [`ISS_TERM_N-1:0]  term_n_sync;

   term_sync u_term_sync (
      .core_clk  (core_clk),
      .srst      (srst),
      .term_raw  (input_terminal_n),
      .term_sync (term_n_sync)
   );

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  strb
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // presets above the setting range are held at its top
   function automatic logic [`ISS_SPEED_W-1:0] limit_preset(
      input logic [31:0] v
   );
      logic [`ISS_SPEED_W-1:0] r;
      if (v > {16'h0000, `ISS_PRESET_MAX}) begin
         r = `ISS_PRESET_MAX;
      end else begin
         r = v[`ISS_SPEED_W-1:0];
      end
      return r;
   endfunction

   // field 0..7 names a terminal, any other value leaves the signal off
   function automatic logic pick_term(
      input logic [`ISS_TERM_N-1:0] on_vec,
      input logic [3:0]             field
   );
      logic r;
      r = 1'b0;
      if (!field[3]) begin
         r = on_vec[field[2:0]];
      end
      return r;
   endfunction

   logic [`ISS_TERM_N-1:0]  term_on;
   logic                    dir_on;
   logic                    sel_a_on;
   logic                    sel_b_on;
   logic [31:0]             rd_word;
   logic                    rd_ok;
   logic [31:0]             wr_old;
   logic                    wr_ok;
   logic [31:0]             wr_val;
   logic [`ISS_SPEED_W-1:0] preset_raw;
   logic [`ISS_CMD_W-1:0]   preset_scaled;
   iss_pkg::preset_sel_t    sel_nx;

   assign term_on = ~term_n_sync;

   // input allocation
   always_comb begin
      if (!q.alloc_mode) begin
         dir_on   = term_on[`ISS_DEF_DIR_TERM];
         sel_a_on = term_on[`ISS_DEF_A_TERM];
         sel_b_on = term_on[`ISS_DEF_B_TERM];
      end else begin
         dir_on   = pick_term(term_on, q.alloc[`ISS_ALLOC_DIR_LSB +: 4]);
         sel_a_on = pick_term(term_on, q.alloc[`ISS_ALLOC_A_LSB +: 4]);
         sel_b_on = pick_term(term_on, q.alloc[`ISS_ALLOC_B_LSB +: 4]);
      end
      // next preset choice, kept apart from the state copy to avoid a loop through it
      if (!sel_a_on && sel_b_on) begin
         sel_nx = iss_pkg::SEL_ONE;
      end else if (sel_a_on && sel_b_on) begin
         sel_nx = iss_pkg::SEL_TWO;
      end else if (sel_a_on && !sel_b_on) begin
         sel_nx = iss_pkg::SEL_THREE;
      end else begin
         sel_nx = iss_pkg::SEL_STOP;
      end
   end

   // register read view
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (s_axi_araddr == `ISS_OFS_METHOD) begin
         rd_word[`ISS_METHOD_LSB +: 4] = q.method_pend;
      end else if (s_axi_araddr == `ISS_OFS_ALLOC_MODE) begin
         rd_word[0] = q.alloc_mode;
      end else if (s_axi_araddr == `ISS_OFS_ALLOC) begin
         rd_word[`ISS_ALLOC_W-1:0] = q.alloc;
      end else if (s_axi_araddr == `ISS_OFS_MOTOR) begin
         rd_word[`ISS_MOTOR_LIN_BIT] = q.linear;
         rd_word[`ISS_MOTOR_DD_BIT]  = q.direct_drive;
      end else if (s_axi_araddr == `ISS_OFS_MAX_SPEED) begin
         rd_word[`ISS_CMD_W-1:0] = q.max_speed;
      end else if (s_axi_araddr == `ISS_OFS_ROT1) begin
         rd_word[`ISS_SPEED_W-1:0] = q.rot_preset[0];
      end else if (s_axi_araddr == `ISS_OFS_ROT2) begin
         rd_word[`ISS_SPEED_W-1:0] = q.rot_preset[1];
      end else if (s_axi_araddr == `ISS_OFS_ROT3) begin
         rd_word[`ISS_SPEED_W-1:0] = q.rot_preset[2];
      end else if (s_axi_araddr == `ISS_OFS_LIN1) begin
         rd_word[`ISS_SPEED_W-1:0] = q.lin_preset[0];
      end else if (s_axi_araddr == `ISS_OFS_LIN2) begin
         rd_word[`ISS_SPEED_W-1:0] = q.lin_preset[1];
      end else if (s_axi_araddr == `ISS_OFS_LIN3) begin
         rd_word[`ISS_SPEED_W-1:0] = q.lin_preset[2];
      end else if (s_axi_araddr == `ISS_OFS_STATUS) begin
         rd_word[3:0] = q.method_act;
         rd_word[4]   = q.mode_active;
         rd_word[6:5] = q.sel;
         rd_word[7]   = q.reverse;
         rd_word[8]   = q.clamped;
         rd_word[9]   = q.stop;
      end else if (s_axi_araddr == `ISS_OFS_RESTART) begin
         rd_word = 32'h0000_0000;
      end else if (s_axi_araddr == `ISS_OFS_SPEED) begin
         rd_word[`ISS_CMD_W-1:0] = q.speed_cmd;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // stored word behind the write address
   always_comb begin
      wr_old = 32'h0000_0000;
      wr_ok  = 1'b1;
      if (q.aw_addr == `ISS_OFS_METHOD) begin
         wr_old[`ISS_METHOD_LSB +: 4] = q.method_pend;
      end else if (q.aw_addr == `ISS_OFS_ALLOC_MODE) begin
         wr_old[0] = q.alloc_mode;
      end else if (q.aw_addr == `ISS_OFS_ALLOC) begin
         wr_old[`ISS_ALLOC_W-1:0] = q.alloc;
      end else if (q.aw_addr == `ISS_OFS_MOTOR) begin
         wr_old[`ISS_MOTOR_LIN_BIT] = q.linear;
         wr_old[`ISS_MOTOR_DD_BIT]  = q.direct_drive;
      end else if (q.aw_addr == `ISS_OFS_MAX_SPEED) begin
         wr_old[`ISS_CMD_W-1:0] = q.max_speed;
      end else if (q.aw_addr == `ISS_OFS_ROT1) begin
         wr_old[`ISS_SPEED_W-1:0] = q.rot_preset[0];
      end else if (q.aw_addr == `ISS_OFS_ROT2) begin
         wr_old[`ISS_SPEED_W-1:0] = q.rot_preset[1];
      end else if (q.aw_addr == `ISS_OFS_ROT3) begin
         wr_old[`ISS_SPEED_W-1:0] = q.rot_preset[2];
      end else if (q.aw_addr == `ISS_OFS_LIN1) begin
         wr_old[`ISS_SPEED_W-1:0] = q.lin_preset[0];
      end else if (q.aw_addr == `ISS_OFS_LIN2) begin
         wr_old[`ISS_SPEED_W-1:0] = q.lin_preset[1];
      end else if (q.aw_addr == `ISS_OFS_LIN3) begin
         wr_old[`ISS_SPEED_W-1:0] = q.lin_preset[2];
      end else if (q.aw_addr == `ISS_OFS_RESTART || q.aw_addr == `ISS_OFS_STATUS
                   || q.aw_addr == `ISS_OFS_SPEED) begin
         wr_old = 32'h0000_0000;
      end else begin
         wr_ok = 1'b0;
      end
   end

   assign wr_val = merge(wr_old, q.w_data, q.w_strb);

   // preset choice by motor type
   always_comb begin
      preset_raw = '0;
      case (sel_nx)
         iss_pkg::SEL_ONE: begin
            preset_raw = q.linear ? q.lin_preset[0] : q.rot_preset[0];
         end
         iss_pkg::SEL_TWO: begin
            preset_raw = q.linear ? q.lin_preset[1] : q.rot_preset[1];
         end
         iss_pkg::SEL_THREE: begin
            preset_raw = q.linear ? q.lin_preset[2] : q.rot_preset[2];
         end
         default: begin
            preset_raw = '0;
         end
      endcase
      // command in 0.1 rpm for rotary motors except direct drive, which passes the preset unscaled; mm/s for linear
      if (q.linear || q.direct_drive) begin
         preset_scaled = {1'b0, preset_raw};
      end else begin
         preset_scaled = ({1'b0, preset_raw} << 3) + ({1'b0, preset_raw} << 1);
      end
   end

   always_comb begin
      d = q;

      // write address and data, taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got  = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = wr_ok ? `ISS_RESP_OKAY : `ISS_RESP_SLVERR;
         if (q.aw_addr == `ISS_OFS_METHOD) begin
            d.method_pend = wr_val[`ISS_METHOD_LSB +: 4];
         end else if (q.aw_addr == `ISS_OFS_ALLOC_MODE) begin
            d.alloc_mode = wr_val[0];
         end else if (q.aw_addr == `ISS_OFS_ALLOC) begin
            d.alloc = wr_val[`ISS_ALLOC_W-1:0];
         end else if (q.aw_addr == `ISS_OFS_MOTOR) begin
            d.linear       = wr_val[`ISS_MOTOR_LIN_BIT];
            d.direct_drive = wr_val[`ISS_MOTOR_DD_BIT];
         end else if (q.aw_addr == `ISS_OFS_MAX_SPEED) begin
            d.max_speed = wr_val[`ISS_CMD_W-1:0];
         end else if (q.aw_addr == `ISS_OFS_ROT1) begin
            d.rot_preset[0] = limit_preset(wr_val);
         end else if (q.aw_addr == `ISS_OFS_ROT2) begin
            d.rot_preset[1] = limit_preset(wr_val);
         end else if (q.aw_addr == `ISS_OFS_ROT3) begin
            d.rot_preset[2] = limit_preset(wr_val);
         end else if (q.aw_addr == `ISS_OFS_LIN1) begin
            d.lin_preset[0] = limit_preset(wr_val);
         end else if (q.aw_addr == `ISS_OFS_LIN2) begin
            d.lin_preset[1] = limit_preset(wr_val);
         end else if (q.aw_addr == `ISS_OFS_LIN3) begin
            d.lin_preset[2] = limit_preset(wr_val);
         end else if (q.aw_addr == `ISS_OFS_RESTART) begin
            if (wr_val[`ISS_RESTART_BIT]) begin
               d.method_act = q.method_pend;
            end
         end
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;

      // read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_word;
         d.rresp  = rd_ok ? `ISS_RESP_OKAY : `ISS_RESP_SLVERR;
      end
      d.arready = !d.rvalid;

      // speed decode
      d.mode_active = (q.method_act == `ISS_METHOD_INTERNAL);
      d.reverse     = dir_on;
      d.sel         = sel_nx;
      if (!d.mode_active || d.sel == iss_pkg::SEL_STOP) begin
         d.speed_cmd = '0;
         d.stop      = 1'b1;
         d.clamped   = 1'b0;
      end else if (preset_scaled > q.max_speed) begin
         d.speed_cmd = q.max_speed;
         d.stop      = 1'b0;
         d.clamped   = 1'b1;
      end else begin
         d.speed_cmd = preset_scaled;
         d.stop      = 1'b0;
         d.clamped   = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q              <= '0;
         q.sel          <= iss_pkg::SEL_STOP;
         q.stop         <= 1'b1;
         q.method_pend  <= `ISS_METHOD_RST;
         q.method_act   <= `ISS_METHOD_RST;
         q.alloc_mode   <= `ISS_ALLOC_MODE_RST;
         q.alloc        <= `ISS_ALLOC_RST;
         q.max_speed    <= `ISS_MAX_SPEED_RST;
         q.rot_preset[0] <= `ISS_ROT1_RST;
         q.rot_preset[1] <= `ISS_ROT2_RST;
         q.rot_preset[2] <= `ISS_ROT3_RST;
         q.lin_preset[0] <= `ISS_LIN1_RST;
         q.lin_preset[1] <= `ISS_LIN2_RST;
         q.lin_preset[2] <= `ISS_LIN3_RST;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign mode_active   = q.mode_active;
   assign speed_cmd     = q.speed_cmd;
   assign speed_reverse = q.reverse;
   assign motor_stop    = q.stop;
   assign preset_index  = q.sel;
   assign speed_clamped = q.clamped;

endmodule

// [design/iss_defines.svh]
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH

// widths
`define ISS_AXI_AW          6
`define ISS_TERM_N          8
`define ISS_SPEED_W         16
`define ISS_CMD_W           17
`define ISS_ALLOC_W         12

// register byte offsets
`define ISS_OFS_METHOD      6'h00
`define ISS_OFS_ALLOC_MODE  6'h04
`define ISS_OFS_ALLOC       6'h08
`define ISS_OFS_MOTOR       6'h0c
`define ISS_OFS_MAX_SPEED   6'h10
`define ISS_OFS_ROT1        6'h14
`define ISS_OFS_ROT2        6'h18
`define ISS_OFS_ROT3        6'h1c
`define ISS_OFS_LIN1        6'h20
`define ISS_OFS_LIN2        6'h24
`define ISS_OFS_LIN3        6'h28
`define ISS_OFS_STATUS      6'h2c
`define ISS_OFS_RESTART     6'h30
`define ISS_OFS_SPEED       6'h34

// field positions
`define ISS_METHOD_LSB      4
`define ISS_ALLOC_DIR_LSB   0
`define ISS_ALLOC_A_LSB     4
`define ISS_ALLOC_B_LSB     8
`define ISS_MOTOR_LIN_BIT   0
`define ISS_MOTOR_DD_BIT    1
`define ISS_RESTART_BIT     0

// values and reset values
`define ISS_METHOD_INTERNAL 4'h3
`define ISS_METHOD_RST      4'h0
`define ISS_ALLOC_MODE_RST  1'h0
`define ISS_ALLOC_RST       12'h888
`define ISS_MAX_SPEED_RST   17'h0ea60
`define ISS_PRESET_MAX      16'h2710
`define ISS_ROT1_RST        16'h0064
`define ISS_ROT2_RST        16'h00c8
`define ISS_ROT3_RST        16'h012c
`define ISS_LIN1_RST        16'h000a
`define ISS_LIN2_RST        16'h0014
`define ISS_LIN3_RST        16'h001e
`define ISS_DEF_DIR_TERM    3'h3
`define ISS_DEF_A_TERM      3'h5
`define ISS_DEF_B_TERM      3'h6
`define ISS_TERM_IDLE       8'hff
`define ISS_RESP_OKAY       2'h0
`define ISS_RESP_SLVERR     2'h2

`endif

// [design/iss_pkg.sv]
`include "iss_defines.svh"

package iss_pkg;

   typedef enum logic [1:0] {
      SEL_STOP,
      SEL_ONE,
      SEL_TWO,
      SEL_THREE
   } preset_sel_t;

   typedef struct packed {
      logic [`ISS_TERM_N-1:0] meta;
      logic [`ISS_TERM_N-1:0] sync;
   } sync_state_t;

   typedef struct packed {
      logic                                aw_got;
      logic [`ISS_AXI_AW-1:0]              aw_addr;
      logic                                w_got;
      logic [31:0]                         w_data;
      logic [3:0]                          w_strb;
      logic                                awready;
      logic                                wready;
      logic                                bvalid;
      logic [1:0]                          bresp;
      logic                                arready;
      logic                                rvalid;
      logic [31:0]                         rdata;
      logic [1:0]                          rresp;
      logic [3:0]                          method_pend;
      logic [3:0]                          method_act;
      logic                                alloc_mode;
      logic [`ISS_ALLOC_W-1:0]             alloc;
      logic                                linear;
      logic                                direct_drive;
      logic [`ISS_CMD_W-1:0]               max_speed;
      logic [2:0][`ISS_SPEED_W-1:0]        rot_preset;
      logic [2:0][`ISS_SPEED_W-1:0]        lin_preset;
      logic                                mode_active;
      preset_sel_t                         sel;
      logic                                reverse;
      logic                                clamped;
      logic                                stop;
      logic [`ISS_CMD_W-1:0]               speed_cmd;
   } iss_state_t;

endpackage

// [design/term_sync.sv]
`include "iss_defines.svh"

// two-stage synchroniser for the input terminals
module term_sync (
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   input  wire logic [`ISS_TERM_N-1:0]  term_raw,
   output logic      [`ISS_TERM_N-1:0]  term_sync
);

   iss_pkg::sync_state_t q;
   iss_pkg::sync_state_t d;

   always_comb begin
      d      = q;
      d.meta = term_raw;
      d.sync = q.meta;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q.meta <= `ISS_TERM_IDLE;
         q.sync <= `ISS_TERM_IDLE;
      end else begin
         q <= d;
      end
   end

   assign term_sync = q.sync;

endmodule

// [bench/iss_assertions.sv]
`include "iss_defines.svh"

module iss_assert (
   input wire logic                   core_clk,
   input wire logic                   srst,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_rvalid,
   input wire logic                   mode_active,
   input wire logic [`ISS_CMD_W-1:0]  speed_cmd,
   input wire logic                   motor_stop,
   input wire logic [1:0]             preset_index,
   input wire logic                   speed_clamped
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   rd_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
      else $error("read response missing");
   one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
   stop_zero_a: assert property (motor_stop |-> speed_cmd == '0)
      else $error("stopped motor with nonzero speed");
   stop_decode_a: assert property (mode_active |-> motor_stop == (preset_index == 2'h0))
      else $error("stop flag disagrees with preset index");
   idle_mode_a: assert property (!mode_active |-> motor_stop && !speed_clamped)
      else $error("speed commanded with mode inactive");
   speed_range_a: assert property (speed_cmd <= 17'h186a0)
      else $error("speed above largest preset");
   clamp_run_a: assert property (speed_clamped |-> !motor_stop)
      else $error("clamp flagged while stopped");
   restart_only_a: assert property ($rose(mode_active) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)
      || $past(s_axi_bvalid, 3)) else $error("mode entered without register write");
   reset_out_a: assert property (disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid && motor_stop)
      else $error("outputs not idle after reset");
endmodule

bind internal_set_speed_selector iss_assert u_iss_assert (.core_clk, .srst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mode_active,
   .speed_cmd, .motor_stop, .preset_index, .speed_clamped);

// [bench/contact_host.sv]
// host contacts: open contacts are pulled up, a closed one pulls its terminal low
module contact_host (
   input  wire logic [2:0]  dir_term,
   input  wire logic [2:0]  a_term,
   input  wire logic [2:0]  b_term,
   input  wire logic        dir_on,
   input  wire logic        a_on,
   input  wire logic        b_on,
   output logic      [7:0]  term_n
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      term_n = 8'hff;
      if (dir_on) term_n[dir_term] = 1'b0;
      if (a_on) term_n[a_term] = 1'b0;
      if (b_on) term_n[b_term] = 1'b0;
   end
endmodule

// [bench/internal_set_speed_selector_tb.sv]
module internal_set_speed_selector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  term_n;
   logic [5:0]  awaddr = '0;
   logic [5:0]  araddr = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, out_chk = 0;
   logic        awready, wready, bvalid, arready, rvalid, mact, rev, stop, clmp;
   logic [1:0]  bresp, rresp, pidx;
   logic [31:0] rdata;
   logic [16:0] cmd;
   logic [2:0]  t_dir = 3'h3, t_a = 3'h5, t_b = 3'h6, on = 3'h0;
   logic [33:0] exp_q[$];
   int          n_fail = 0, samples_checked = 0;
   logic [31:0] seed = 32'hd54c80c9;
   logic [15:0] rot[3] = '{16'h0064, 16'h00c8, 16'h012c};
   logic [15:0] lin[3] = '{16'h000a, 16'h0014, 16'h001e};
   logic [2:0]  pat[3] = '{3'b001, 3'b011, 3'b010};
   logic [16:0] maxs = 17'h0ea60;
   logic        linear = 0, dd = 0;

   always #2.5 core_clk = ~core_clk;

   internal_set_speed_selector DUT (.core_clk(core_clk), .srst(srst), .input_terminal_n(term_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mode_active(mact), .speed_cmd(cmd), .speed_reverse(rev),
      .motor_stop(stop), .preset_index(pidx), .speed_clamped(clmp));

   contact_host host (.dir_term(t_dir), .a_term(t_a), .b_term(t_b), .dir_on(on[2]), .a_on(on[1]),
      .b_on(on[0]), .term_n(term_n));

   task automatic summarize;
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp(input logic [33:0] got);
      logic [33:0] e;
      samples_checked++;
      e = exp_q.size() > 0 ? exp_q.pop_front() : 34'hx;
      if (got !== e) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, e);
      end
   endtask

   always @(posedge core_clk) begin
      if (bvalid && bready) cmp({bresp, 32'h0});
      if (rvalid && rready) cmp({rresp, rdata});
      if (out_chk) cmp({11'h0, mact, rev, stop, pidx, clmp, cmd});
   end

   task automatic hang;
      n_fail++;
      $display("ERROR %0t handshake timeout", $time);
      summarize();
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      exp_q.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      if (n == 40) hang();
   endtask

   task automatic rd(input logic [5:0] a, input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      if (n == 40) hang();
   endtask

   function automatic logic [22:0] expect_out(input logic [2:0] p);
      logic [1:0]  idx;
      logic [16:0] raw;
      idx = p[1] ? (p[0] ? 2'h2 : 2'h3) : (p[0] ? 2'h1 : 2'h0);
      raw = 17'h0;
      if (idx != 2'h0) raw = linear ? 17'(lin[idx-1]) : dd ? 17'(rot[idx-1]) : 17'(rot[idx-1]) * 17'd10;
      return {1'b1, p[2], idx == 2'h0, idx, raw > maxs, raw > maxs ? maxs : raw};
   endfunction

   // pins {direction, a, b} driven as p, decoded as e; held well past the synchroniser delay
   task automatic sel(input logic [2:0] p, input logic [2:0] e);
      on <= p;
      repeat (4) @(posedge core_clk);
      exp_q.push_back({11'h0, expect_out(e)});
      out_chk <= 1'b1;
      @(posedge core_clk);
      out_chk <= 1'b0;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   initial begin
      int k;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      for (k = 0; k < 3; k++) begin
         rd(6'h14 + 6'(4 * k), {18'h0, rot[k]});
         rd(6'h20 + 6'(4 * k), {18'h0, lin[k]});
      end
      rd(6'h08, {2'h0, 32'h888});
      rd(6'h38, {2'h2, 32'h0});
      wr(6'h3c, 32'h5, 2'h2);
      wr(6'h00, 32'h30, 2'h0);
      rd(6'h2c, {2'h0, 32'h200});
      wr(6'h30, 32'h1, 2'h0);
      for (k = 0; k < 8; k++) sel(3'(k), 3'(k));
      rd(6'h2c, {2'h0, 32'hd3});
      rd(6'h34, {2'h0, 32'h7d0});
      for (k = 0; k < 6; k++) begin
         seed = xs(seed);
         rot[k % 3] = 16'(seed % 32'd10001);
         wr(6'h14 + 6'(4 * (k % 3)), {16'h0, rot[k % 3]}, 2'h0);
         sel({seed[20], pat[k % 3][1:0]}, {seed[20], pat[k % 3][1:0]});
      end
      dd = 1'b1;
      wr(6'h0c, 32'h2, 2'h0);
      sel(3'b011, 3'b011);
      dd = 1'b0;
      linear = 1'b1;
      wr(6'h0c, 32'h1, 2'h0);
      for (k = 0; k < 3; k++) sel(pat[k], pat[k]);
      wr(6'h20, 32'd10001, 2'h0);
      rd(6'h20, {2'h0, 32'd10000});
      maxs = 17'd15;
      wr(6'h10, 32'd15, 2'h0);
      sel(3'b011, 3'b011);
      wr(6'h04, 32'h1, 2'h0);
      sel(3'b111, 3'b000);
      t_dir <= 3'h0;
      t_a <= 3'h1;
      t_b <= 3'h2;
      wr(6'h08, 32'h210, 2'h0);
      sel(3'b110, 3'b110);
      summarize();
   end
endmodule
